// ---- verilog/atc_converter_ctrl.sv ----
`timescale 1ns/1ns
`include "atc_defines.svh"

module atc_converter_ctrl
    import atc_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int PACER_W = 16,
    parameter int FIFO_DEPTH = 8
)
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [`ATC_ADDR_W-1:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    input wire logic external_trigger_input_in,
    input wire logic [CODE_W-1:0] adc_code_in,
    output logic adc_start_out,
    output logic [`ATC_CHAN_W-1:0] chan_sel_out,
    output logic [3:0] gain_out,
    output logic irq_out,
    output logic dma_valid_out,
    output logic [CODE_W+`ATC_CHAN_W-1:0] dma_data_out,
    input wire logic dma_ready_in,
    output logic [CODE_W-1:0] analog_out_first_out,
    output logic [CODE_W-1:0] analog_out_second_out
);
    localparam int RES_W = CODE_W + `ATC_CHAN_W;
    localparam int CONV_CW = $clog2(`ATC_CONV_CYCLES);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [`ATC_CTRL_W-1:0] ctrl, next_ctrl;
    logic [PACER_W-1:0] pacer_lo, pacer_hi, next_pacer_lo, next_pacer_hi;
    logic [PACER_W-1:0] cnt_lo, cnt_hi, next_cnt_lo, next_cnt_hi;
    atc_state_e state, next_state;
    logic [CONV_CW-1:0] conv_cnt, next_conv_cnt;
    logic conversion_done_flag, next_done;
    logic overrun_flag, next_ovr;
    logic [RES_W-1:0] result, next_result;
    atc_chan_t chan, next_chan;
    logic [CODE_W-1:0] dac_first, dac_second, next_dac_first, next_dac_second;
    logic [31:0] rdata, next_rdata;
    logic irq, next_irq, start, next_start;
    logic ext_s1, ext_s2, ext_s3;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic ctrl_wr, kick_wr, low_rd, ext_edge, sw_trig, pacer_trig;
    logic trig, legal, pacer_mode, conv_end, push_valid, push_ready;
    logic trigger_source_select, internal_trigger_select;
    logic interrupt_transfer_enable, bus_master_transfer_enable;

    // only six pairings of trigger and transfer are accepted
    function automatic logic mode_legal(input logic [3:0] m);
        if (m[3])
            return (m[1:0] != 2'b11);
        else if (m[2])
            return (m[1:0] == 2'b01) || (m[1:0] == 2'b10);
        else
            return (m[1:0] == 2'b00);
    endfunction

    assign trigger_source_select = ctrl[`ATC_BIT_TRIGGER_SOURCE_SELECT];
    assign internal_trigger_select = ctrl[`ATC_BIT_INTERNAL_TRIGGER_SELECT];
    assign interrupt_transfer_enable = ctrl[`ATC_BIT_INT];
    assign bus_master_transfer_enable = ctrl[`ATC_BIT_DMA];
    assign legal = mode_legal(ctrl[`ATC_BIT_TRIGGER_SOURCE_SELECT:`ATC_BIT_DMA]);

    assign ctrl_wr = wr_in && (addr_in == `ATC_OFF_CTRL);
    assign kick_wr = wr_in && (addr_in == `ATC_OFF_KICK);
    assign low_rd = rd_in && (addr_in == `ATC_OFF_AD_DATA);

    // the second flop only feeds the third and the edge gate
    assign ext_edge = ext_s2 && !ext_s3;

    // three sources from two select bits; external masks both internal
    assign pacer_mode = !trigger_source_select && internal_trigger_select;
    assign sw_trig = kick_wr && !trigger_source_select && !internal_trigger_select;
    assign pacer_trig = pacer_mode && (cnt_lo == PACER_W'(1)) && (cnt_hi == PACER_W'(1));
    always_comb
    begin
        if (trigger_source_select)
            trig = ext_edge;
        else
            trig = sw_trig || pacer_trig;
        // a trigger while busy is dropped, never restarts the converter
        trig = trig && legal && (state == ATC_IDLE);
    end

    // done must already show at the edge that closes the allowed span, so end one cycle early
    assign conv_end = (state == ATC_CONV) && (conv_cnt == CONV_CW'(`ATC_CONV_CYCLES - 2));
    assign push_valid = conv_end && bus_master_transfer_enable;

    // ----------------------------------------
    // result queue
    // ----------------------------------------
    atc_stream_if #(.W(RES_W)) strm ();

    assign strm.in_valid = push_valid;
    assign strm.in_data = {chan, adc_code_in};
    assign strm.out_ready = dma_ready_in;
    assign push_ready = strm.in_ready;
    assign dma_valid_out = strm.out_valid;
    assign dma_data_out = strm.out_data;

    atc_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .s(strm.store)
    );

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb
    begin
        next_ctrl = ctrl_wr ? wdata_in[`ATC_CTRL_W-1:0] : ctrl;
        next_pacer_lo = pacer_lo;
        next_pacer_hi = pacer_hi;
        next_cnt_lo = cnt_lo;
        next_cnt_hi = cnt_hi;
        next_state = state;
        next_conv_cnt = conv_cnt;
        next_done = conversion_done_flag;
        next_ovr = overrun_flag;
        next_result = result;
        next_chan = chan;
        next_dac_first = dac_first;
        next_dac_second = dac_second;
        next_rdata = rdata;
        next_irq = conv_end && interrupt_transfer_enable;
        next_start = trig;

        // pacer divisors; a write restarts the chain
        if (wr_in && (addr_in == `ATC_OFF_PACER_LO))
            next_pacer_lo = wdata_in[PACER_W-1:0];
        if (wr_in && (addr_in == `ATC_OFF_PACER_HI))
            next_pacer_hi = wdata_in[PACER_W-1:0];

        // lower counter divides the clock, upper divides its wraps
        if (!pacer_mode || wr_in)
        begin
            next_cnt_lo = next_pacer_lo;
            next_cnt_hi = next_pacer_hi;
        end
        else if (cnt_lo == PACER_W'(1))
        begin
            next_cnt_lo = pacer_lo;
            next_cnt_hi = (cnt_hi == PACER_W'(1)) ? pacer_hi : cnt_hi - 1'b1;
        end
        else
            next_cnt_lo = cnt_lo - 1'b1;

        // two independent twelve-bit outputs
        if (wr_in && (addr_in == `ATC_OFF_DAC_FIRST))
            next_dac_first = wdata_in[CODE_W-1:0];
        if (wr_in && (addr_in == `ATC_OFF_DAC_SECOND))
            next_dac_second = wdata_in[CODE_W-1:0];

        // channel 0..15; single-ended or differential is a jumper matter
        if (ctrl_wr)
            next_chan = wdata_in[`ATC_MUX_MSB:`ATC_MUX_LSB];
        else if (conv_end)
        begin
            if (ctrl[`ATC_BIT_SCAN] && (chan != '0))
                next_chan = chan - 1'b1;
            else
                next_chan = ctrl[`ATC_MUX_MSB:`ATC_MUX_LSB];
        end

        // sequencer
        case (state)
            ATC_IDLE:
            begin
                next_conv_cnt = '0;
                if (trig)
                    next_state = ATC_CONV;
            end
            ATC_CONV:
            begin
                next_conv_cnt = conv_cnt + 1'b1;
                if (conv_end)
                begin
                    next_state = ATC_IDLE;
                    next_result = {chan, adc_code_in};
                end
            end
            default:
                next_state = ATC_IDLE;
        endcase

        // done flag: cleared by start or low-byte read, completion wins
        if (trig || low_rd)
            next_done = 1'b0;
        if (conv_end)
            next_done = 1'b1;

        // overrun: queue full at completion; control write clears, set wins
        if (ctrl_wr)
            next_ovr = 1'b0;
        if (push_valid && !push_ready)
            next_ovr = 1'b1;

        // read data is registered and holds until the next read
        if (rd_in)
        begin
            if (addr_in == `ATC_OFF_CTRL)
            begin
                next_rdata = '0;
                next_rdata[`ATC_STAT_DONE] = conversion_done_flag;
                next_rdata[`ATC_STAT_OVR] = overrun_flag;
            end
            else if (addr_in == `ATC_OFF_AD_DATA)
                next_rdata = {{(32 - RES_W){1'b0}}, result};
            else
                next_rdata = '0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            ctrl <= `ATC_CTRL_RST;
            pacer_lo <= `ATC_PACER_RST;
            pacer_hi <= `ATC_PACER_RST;
            cnt_lo <= `ATC_PACER_RST;
            cnt_hi <= `ATC_PACER_RST;
            state <= ATC_IDLE;
            conv_cnt <= '0;
            conversion_done_flag <= 1'b0;
            overrun_flag <= 1'b0;
            result <= '0;
            chan <= '0;
            dac_first <= '0;
            dac_second <= '0;
            rdata <= '0;
            irq <= 1'b0;
            start <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            pacer_lo <= next_pacer_lo;
            pacer_hi <= next_pacer_hi;
            cnt_lo <= next_cnt_lo;
            cnt_hi <= next_cnt_hi;
            state <= next_state;
            conv_cnt <= next_conv_cnt;
            conversion_done_flag <= next_done;
            overrun_flag <= next_ovr;
            result <= next_result;
            chan <= next_chan;
            dac_first <= next_dac_first;
            dac_second <= next_dac_second;
            rdata <= next_rdata;
            irq <= next_irq;
            start <= next_start;
            ext_s1 <= external_trigger_input_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    assign rdata_out = rdata;
    assign adc_start_out = start;
    assign irq_out = irq;
    assign chan_sel_out = chan;
    assign gain_out = ctrl[`ATC_GAIN_MSB:`ATC_GAIN_LSB];
    assign analog_out_first_out = dac_first;
    assign analog_out_second_out = dac_second;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int AST_CONV_MAX = `ATC_CONV_CYCLES;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    AST_START_CLEARS_DONE: assert property (trig |=> !conversion_done_flag && adc_start_out)
        else $error("start did not clear done flag");
    AST_CONV_BOUND: assert property (trig |-> ##[1:AST_CONV_MAX] conversion_done_flag)
        else $error("conversion exceeded its time bound");
    AST_EXT_MASKS: assert property (trigger_source_select && !ext_edge |=> !adc_start_out)
        else $error("internal trigger taken in external mode");
    AST_KICK_STARTS: assert property (kick_wr && state == ATC_IDLE
        && ctrl[`ATC_BIT_TRIGGER_SOURCE_SELECT:`ATC_BIT_DMA] == 4'h0 |=> adc_start_out)
        else $error("kick write did not start a conversion");
    AST_READ_CLEARS: assert property (low_rd && !conv_end |=> !conversion_done_flag)
        else $error("low byte read left done flag set");
    AST_IRQ_AT_END: assert property (irq_out |-> $past(conv_end)
        && $past(interrupt_transfer_enable) && conversion_done_flag)
        else $error("interrupt without a finished conversion");
    AST_BUSY_HOLDS: assert property (state == ATC_CONV && !conv_end
        |=> state == ATC_CONV && conv_cnt == $past(conv_cnt) + 1'b1)
        else $error("conversion disturbed while busy");
    AST_EDGE_ONCE: assert property (ext_edge |=> !ext_edge)
        else $error("external edge gave more than one pulse");
    AST_SCAN_STEP: assert property (conv_end && ctrl[`ATC_BIT_SCAN]
        && chan != '0 && !ctrl_wr |=> chan == $past(chan) - 1'b1)
        else $error("auto-scan did not step down");
    AST_OVERRUN: assert property (push_valid && !push_ready |=> overrun_flag)
        else $error("overrun not flagged on full queue");
    AST_PACER_FIRES: assert property (pacer_trig && legal && state == ATC_IDLE
        |=> adc_start_out)
        else $error("pacer tick did not start conversion");

    CVR_EXT_DMA: cover property (trigger_source_select && push_valid);
    CVR_PACER_INT: cover property (pacer_mode && irq_out);
    CVR_SW_POLL: cover property (kick_wr ##[1:AST_CONV_MAX] low_rd);
endmodule

// ---- include/atc_defines.svh ----
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ATC_ADDR_W 6
`define ATC_OFF_PACER_LO 6'h04
`define ATC_OFF_PACER_HI 6'h08
`define ATC_OFF_AD_DATA 6'h10
`define ATC_OFF_DAC_FIRST 6'h10
`define ATC_OFF_DAC_SECOND 6'h14
`define ATC_OFF_CTRL 6'h18
`define ATC_OFF_KICK 6'h20

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define ATC_CTRL_W 13
`define ATC_BIT_DMA 0
`define ATC_BIT_INT 1
`define ATC_BIT_INTERNAL_TRIGGER_SELECT 2
`define ATC_BIT_TRIGGER_SOURCE_SELECT 3
`define ATC_BIT_SCAN 4
`define ATC_MUX_LSB 5
`define ATC_MUX_MSB 8
`define ATC_GAIN_LSB 9
`define ATC_GAIN_MSB 12
`define ATC_STAT_DONE 0
`define ATC_STAT_OVR 1
`define ATC_CHAN_W 4

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define ATC_CTRL_RST 13'h0000
`define ATC_PACER_RST 16'h0002
`define ATC_CLK_PERIOD_NS 8
`define ATC_CONV_MAX_NS 8000
`define ATC_CONV_CYCLES (`ATC_CONV_MAX_NS / `ATC_CLK_PERIOD_NS)

`endif

// ---- include/atc_pkg.sv ----
package atc_pkg;
    // conversion sequencer states
    typedef enum logic [0:0]
    {
        ATC_IDLE = 1'b0,
        ATC_CONV = 1'b1
    } atc_state_e;

    typedef logic [3:0] atc_chan_t;
endpackage

// ---- include/atc_stream_if.sv ----
`timescale 1ns/1ns
// result stream between the sequencer and its queue
interface atc_stream_if #(parameter int W = 16);
    logic [W-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport source (output in_data, output in_valid, input in_ready,
                    input out_data, input out_valid, output out_ready);
    modport store (input in_data, input in_valid, output in_ready,
                   output out_data, output out_valid, input out_ready);
endinterface

// ---- verilog/atc_fifo.sv ----
`timescale 1ns/1ns
module atc_fifo
#(
    parameter int W = 16,
    parameter int DEPTH = 8
)
(
    input wire logic mclk_in,
    input wire logic reset_in,
    atc_stream_if.store s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1))
            return '0;
        return p + 1'b1;
    endfunction

    // ----------------------------------------
    // handshake and pointers
    // ----------------------------------------
    // ready drops at full so the sequencer sees back-pressure
    assign s.in_ready = (count != (AW + 1)'(DEPTH));
    assign s.out_valid = (count != '0);
    assign s.out_data = mem[rd_ptr];
    assign push = s.in_valid && s.in_ready;
    assign pop = s.out_valid && s.out_ready;

    always_comb
    begin
        next_wr_ptr = push ? wrap_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? wrap_inc(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    // storage is not reset; count alone says what is valid
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push)
            mem[wr_ptr] <= s.in_data;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    AST_FIFO_FULL: assert property (count == (AW + 1)'(DEPTH) |-> !s.in_ready)
        else $error("fifo accepts data while full");
    AST_FIFO_FILL: assert property (push && !pop |=> count == $past(count) + 1'b1)
        else $error("fifo count did not rise on push");
    CVR_FIFO_FULL: cover property (count == (AW + 1)'(DEPTH));
endmodule

// ---- sim/atc_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// host side: converter front end and bus master sink
// ----------------------------------------
module atc_host_model
(
    input wire logic mclk_in,
    input wire logic stall_in,
    input wire logic [3:0] chan_in,
    input wire logic dma_valid_in,
    input wire logic [15:0] dma_data_in,
    output logic [11:0] adc_code_out,
    output logic dma_ready_out
);
    logic [15:0] got[$];

    // the code carries the channel, so a queued word shows its source
    assign adc_code_out = {8'hC3, chan_in};

    // a stalled host takes nothing, which lets the queue fill
    assign dma_ready_out = !stall_in;

    // collect each word popped by the bus master
    always @(posedge mclk_in)
    begin
        if (dma_valid_in === 1'b1 && dma_ready_out === 1'b1)
        begin
            got.push_back(dma_data_in);
        end
    end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [5:0] addr_in = 6'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] wdata_in = 32'h0;
    logic ext_in = 1'b0;
    logic stall = 1'b0;
    logic [31:0] rdata_out;
    logic [11:0] code, ao1, ao2;
    logic [3:0] chan, gain;
    logic start, irq, dvalid, dready;
    logic [15:0] ddata;
    logic [31:0] v;
    logic [3:0] c;
    int err_total = 0;
    int n_compared = 0;
    int starts = 0;
    int irqs = 0;
    int s0, i0;

    // ----------------------------------------
    // clock, design and host model
    // ----------------------------------------
    initial
    begin
        forever #4 mclk_in = ~mclk_in;
    end

    atc_converter_ctrl DUT (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .external_trigger_input_in(ext_in), .adc_code_in(code), .adc_start_out(start),
        .chan_sel_out(chan), .gain_out(gain), .irq_out(irq), .dma_valid_out(dvalid),
        .dma_data_out(ddata), .dma_ready_in(dready), .analog_out_first_out(ao1),
        .analog_out_second_out(ao2));

    atc_host_model PARTNER (.mclk_in(mclk_in), .stall_in(stall), .chan_in(chan),
        .dma_valid_in(dvalid), .dma_data_in(ddata), .adc_code_out(code),
        .dma_ready_out(dready));

    // count start and interrupt pulses mid-cycle, where each one-cycle pulse is settled
    always @(negedge mclk_in)
    begin
        if (start === 1'b1)
            starts++;
        if (irq === 1'b1)
            irqs++;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("mismatch %s exp %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(negedge mclk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge mclk_in);
        wr_in = 1'b0;
    endtask

    // answer is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [5:0] a, output logic [31:0] r);
        @(negedge mclk_in);
        addr_in = a;
        rd_in = 1'b1;
        @(negedge mclk_in);
        rd_in = 1'b0;
        r = rdata_out;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
        reset_in = 1'b0;
        rd(6'h18, v);
        chk("status after reset", v, 32'h0);
        rd(6'h3C, v);
        chk("unmapped read", v, 32'h0);
        $display("test reset done");

        // software trigger; a second kick lands mid-conversion
        s0 = starts;
        wr(6'h20, 32'hFFFF_FFFF);
        wr(6'h20, 32'h0);
        cyc(985);
        rd(6'h18, v);
        chk("done while busy", v & 32'h1, 32'h0);
        chk("software starts", starts - s0, 1);
        cyc(9);
        rd(6'h18, v);
        chk("done in time", v & 32'h1, 32'h1);
        rd(6'h10, v);
        chk("software result", v, 32'h0000_0C30);
        rd(6'h18, v);
        chk("done after read", v & 32'h1, 32'h0);
        $display("test software done");

        // two converter outputs, only the low twelve bits count
        wr(6'h10, 32'hFFFF_FABC);
        wr(6'h14, 32'h0000_0123);
        cyc(1);
        chk("first output", {20'h0, ao1}, 32'h0000_0ABC);
        chk("second output", {20'h0, ao2}, 32'h0000_0123);
        $display("test output done");

        // software trigger with both transfer bits is not a legal mode
        wr(6'h18, 32'h0000_0003);
        s0 = starts;
        wr(6'h20, 32'h0);
        cyc(10);
        chk("illegal mode starts", starts - s0, 0);
        $display("test illegal done");

        // external trigger with interrupt, channel 3, gain 15
        wr(6'h18, 32'h0000_1E6A);
        s0 = starts;
        i0 = irqs;
        wr(6'h20, 32'h0);
        cyc(10);
        chk("kick in external mode", starts - s0, 0);
        chk("gain field", {28'h0, gain}, 32'h0000_000F);
        ext_in = 1'b1;
        cyc(5);
        ext_in = 1'b0;
        cyc(1020);
        chk("external starts", starts - s0, 1);
        chk("interrupts", irqs - i0, 1);
        rd(6'h10, v);
        chk("external result", v, 32'h0000_3C33);
        $display("test external done");

        // pacer with queueing and auto-scan from channel 2, host stalled
        stall = 1'b1;
        i0 = irqs;
        wr(6'h04, 32'h0000_0002);
        wr(6'h08, 32'h0000_0002);
        wr(6'h18, 32'h0000_0055);
        cyc(9200);
        rd(6'h18, v);
        chk("overrun", v & 32'h2, 32'h2);
        wr(6'h18, 32'h0);
        stall = 1'b0;
        cyc(20);
        chk("queued words", PARTNER.got.size(), 8);
        for (int k = 0; k < 8; k++)
        begin
            c = 4'(2 - k % 3);
            chk("queued word", PARTNER.got[k], {16'h0, c, 8'hC3, c});
        end
        chk("no interrupt in dma", irqs - i0, 0);
        $display("test pacer done");
        summarize();
    end

    // the tests need about 11500 cycles; twice that means a hang
    initial
    begin
        #184000;
        err_total++;
        summarize();
    end
endmodule
